// [rtl/rxem_regs.sv]
// Frame-handling options, receive-enable mask and low exception flags.
// Assumes strobes, instructions and the register port are synchronous
// to CLOCK, each strobe one cycle long, and CE gating all state.
`timescale 1ns/100ps
`include "rxem_map.svh"

module rxem_regs
   import rxem_pkg::*;
(
   input  wire logic          CLOCK,
   input  wire logic          SRST,
   input  wire logic          CE,
   input  wire rxem_addr_type ADDR,
   input  wire rxem_byte_type WDATA,
   input  wire logic          WR,
   input  wire logic          RD,
   output      rxem_byte_type RDATA,
   input  wire logic          BIT_SET_INS,
   input  wire logic          BIT_CLR_INS,
   input  wire logic [3:0]    BIT_INDEX,
   input  wire logic          TRANSMIT_ON_STROBE,
   input  wire logic          RECEIVE_ON_STROBE,
   input  wire logic          RADIO_OFF_STROBE,
   input  wire logic          MASK_OR_INSTRUCTION,
   input  wire rxem_mask_type OR_OPERAND,
   input  wire logic          MASK_AND_INSTRUCTION,
   input  wire rxem_mask_type AND_OPERAND,
   input  wire logic          BIT13_SET_STROBE,
   input  wire logic          BIT13_CLEAR_STROBE,
   input  wire logic [6:0]    EXC_EVENT,
   input  wire logic          ACK_PENDING_IN,
   input  wire logic          TX_UNDERRUN_IN,
   output      rxem_mask_type RX_ENABLE_MASK,
   output      logic          RX_AUTO_ENABLE,
   output      logic          ACK_PENDING_OUT,
   output      logic          TX_ABORT,
   output      rxem_byte_type EXCEPTION_PENDING,
   output      logic          IRQ
);

   rxem_state_type r;
   rxem_state_type next_r;

   // Decodes of the register port.
   logic wr_ctrl;
   logic wr_lo;
   logic wr_hi;
   logic wr_exc;
   logic wr_imask;
   logic rd_istat;
   assign wr_ctrl  = WR && (ADDR == `RXEM_OFF_CTRL);
   assign wr_lo    = WR && (ADDR == `RXEM_OFF_MASK_LO);
   assign wr_hi    = WR && (ADDR == `RXEM_OFF_MASK_HI);
   assign wr_exc   = WR && (ADDR == `RXEM_OFF_EXC_LO);
   assign wr_imask = WR && (ADDR == `RXEM_OFF_IRQ_MASK);
   assign rd_istat = RD && (ADDR == `RXEM_OFF_IRQ_STAT);

   // Per-bit resolution of all mask sources.
   rxem_mask_type bus_sel;
   rxem_mask_type bus_val;
   rxem_mask_type stb_val;
   rxem_mask_type mask_new;

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++)
      begin : g_bit
         logic hit;
         logic wr_byte;
         assign hit = (BIT_INDEX == 4'(gi));
         // low byte at lower address, high byte above.
         assign wr_byte = (gi < 8) ? wr_lo : wr_hi;
         // writes and single-bit instructions reach every bit.
         assign bus_sel[gi] = wr_byte || ((BIT_SET_INS || BIT_CLR_INS) && hit);
         assign bus_val[gi] = wr_byte ? WDATA[gi % 8] : BIT_SET_INS;
         // fixed order among strobes, highest first.
         // Each source except the radio-off strobe only claims a bit it really changes,
         // so the other sources acting on different bits never shadow one another.
         always_comb
         begin
            if (RADIO_OFF_STROBE)
               stb_val[gi] = 1'b0;
            // transmit strobe sets bit 14 when enabled.
            else if (TRANSMIT_ON_STROBE && r.ctrl[`RXEM_CTRL_TXSET]
                     && gi == `RXEM_BIT_TXON)
               stb_val[gi] = 1'b1;
            else if (RECEIVE_ON_STROBE && gi == `RXEM_BIT_RXON)
               stb_val[gi] = 1'b1;
            // OR only changes bits where its operand is one.
            else if (MASK_OR_INSTRUCTION && OR_OPERAND[gi])
               stb_val[gi] = 1'b1;
            // AND only changes bits where its operand is zero.
            else if (MASK_AND_INSTRUCTION && !AND_OPERAND[gi])
               stb_val[gi] = 1'b0;
            // dedicated set and clear of bit 13.
            else if (BIT13_SET_STROBE && gi == `RXEM_BIT_STB13)
               stb_val[gi] = 1'b1;
            else if (BIT13_CLEAR_STROBE && gi == `RXEM_BIT_STB13)
               stb_val[gi] = 1'b0;
            else
               stb_val[gi] = r.mask[gi];
         end
         // data bus overrides, untouched bits keep strobe result.
         assign mask_new[gi] = bus_sel[gi] ? bus_val[gi] : stb_val[gi];
      end
   endgenerate

   // Exception events, with the internally detected ones merged in.
   rxem_byte_type exc_ev;
   always_comb
   begin
      exc_ev = {1'b0, EXC_EVENT};
      // an ignored underrun is not detected and raises nothing.
      if (r.ctrl[`RXEM_CTRL_UNDIGN])
         exc_ev[`RXEM_EXC_UNDERRUN] = 1'b0;
      // mask falling to zero raises its exception.
      exc_ev[`RXEM_EXC_MASKZERO] = (r.mask != 16'h0000)
                                   && (mask_new == 16'h0000);
   end

   // Next-state assembly of the whole bank.
   always_comb
   begin
      next_r = r;
      next_r.mask = mask_new;
      // only the three low control bits exist.
      if (wr_ctrl)
         next_r.ctrl = WDATA[2:0];
      // writes may only drop flags; events set them, set wins.
      if (wr_exc)
         next_r.exc = (r.exc & WDATA) | exc_ev;
      else
         next_r.exc = r.exc | exc_ev;
      if (wr_imask)
         next_r.irq_mask = WDATA;
      // Reading the status empties it, but an event in that cycle stays.
      if (rd_istat)
         next_r.irq_stat = exc_ev;
      else
         next_r.irq_stat = r.irq_stat | exc_ev;
      next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
      // non-zero mask asks the main state machine for receive.
      next_r.rx_auto = (mask_new != 16'h0000);
      // force bit overrides the filtered pending bit.
      next_r.ack_pend = r.ctrl[`RXEM_CTRL_ACKFRC] || ACK_PENDING_IN;
      next_r.tx_abort = TX_UNDERRUN_IN && !r.ctrl[`RXEM_CTRL_UNDIGN];
      // Read data stand one cycle, zero otherwise and for holes.
      next_r.rdata = `RXEM_BYTE_RESET;
      if (RD)
      begin
         case (ADDR)
            `RXEM_OFF_CTRL:     next_r.rdata = {5'h00, r.ctrl};
            `RXEM_OFF_MASK_LO:  next_r.rdata = r.mask[7:0];
            `RXEM_OFF_MASK_HI:  next_r.rdata = r.mask[15:8];
            `RXEM_OFF_EXC_LO:   next_r.rdata = r.exc;
            `RXEM_OFF_IRQ_STAT: next_r.rdata = r.irq_stat;
            `RXEM_OFF_IRQ_MASK: next_r.rdata = r.irq_mask;
            default:            next_r.rdata = `RXEM_BYTE_RESET;
         endcase
      end
   end

   // State register; CE low freezes everything including read data.
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         r          <= '0;
         r.ctrl     <= `RXEM_CTRL_RESET;
         r.mask     <= `RXEM_MASK_RESET;
      end
      else if (CE)
         r <= next_r;
   end

   assign RDATA             = r.rdata;
   assign RX_ENABLE_MASK    = r.mask;
   assign RX_AUTO_ENABLE    = r.rx_auto;
   assign ACK_PENDING_OUT   = r.ack_pend;
   assign TX_ABORT          = r.tx_abort;
   assign EXCEPTION_PENDING = r.exc;
   assign IRQ               = r.irq;

   // Checks of the bank's behaviour.
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SRST);

   a_radio_off_clear: assert property (
      CE && RADIO_OFF_STROBE && bus_sel == 16'h0000
      |=> RX_ENABLE_MASK == 16'h0000)
      else $error("radio off did not clear the mask");

   a_rx_on_bit15: assert property (
      CE && RECEIVE_ON_STROBE && !RADIO_OFF_STROBE && !bus_sel[15]
      |=> RX_ENABLE_MASK[15])
      else $error("receive strobe did not set bit 15");

   a_tx_on_bit14: assert property (
      CE && TRANSMIT_ON_STROBE && r.ctrl[0] && !RADIO_OFF_STROBE
      && !bus_sel[14] |=> RX_ENABLE_MASK[14])
      else $error("transmit strobe did not set bit 14");

   a_bus_beats_strobe: assert property (
      CE && wr_lo |=> RX_ENABLE_MASK[7:0] == $past(WDATA))
      else $error("bus write lost against a strobe");

   a_flag_sticky: assert property (
      CE && !wr_exc ##1 1'b1 |-> (r.exc & $past(r.exc)) == $past(r.exc))
      else $error("exception flag fell without a zero write");

   a_zero_event: assert property (
      $past(r.mask) != 16'h0000 && r.mask == 16'h0000
      |-> EXCEPTION_PENDING[7])
      else $error("mask went zero without its exception");

   a_ack_force: assert property (
      CE && r.ctrl[2] |=> ACK_PENDING_OUT)
      else $error("forced ack pending bit not sent as one");

   a_underrun_abort: assert property (
      CE && TX_UNDERRUN_IN |=> TX_ABORT == !$past(r.ctrl[1]))
      else $error("underrun abort disagrees with ignore bit");

   a_reserved_zero: assert property (
      CE && RD && ADDR == `RXEM_OFF_CTRL |=> RDATA[7:3] == 5'h00)
      else $error("reserved control bits not zero");

   a_auto_enable: assert property (
      CE ##1 1'b1 |-> RX_AUTO_ENABLE == (RX_ENABLE_MASK != 16'h0000))
      else $error("receive enable request disagrees with mask");

   // Further checks of mask sources, flags and the interrupt level.
   // OR leaves every operand bit set.
   a_mask_or_bits: assert property (
      CE && MASK_OR_INSTRUCTION && !RADIO_OFF_STROBE && bus_sel == 16'h0000
      |=> (RX_ENABLE_MASK & $past(OR_OPERAND)) == $past(OR_OPERAND))
      else $error("mask OR did not set operand bits");

   // AND alone leaves the plain bitwise product.
   a_mask_and_only: assert property (
      CE && MASK_AND_INSTRUCTION && !RADIO_OFF_STROBE && !TRANSMIT_ON_STROBE
      && !RECEIVE_ON_STROBE && !MASK_OR_INSTRUCTION && !BIT13_SET_STROBE
      && !BIT13_CLEAR_STROBE && bus_sel == 16'h0000
      |=> RX_ENABLE_MASK == ($past(RX_ENABLE_MASK) & $past(AND_OPERAND)))
      else $error("mask AND gave a wrong product");

   // bit set reaches the indexed bit.
   a_bit_set_any: assert property (
      CE && BIT_SET_INS && !wr_lo && !wr_hi
      |=> RX_ENABLE_MASK[$past(BIT_INDEX)])
      else $error("bit set instruction missed its bit");

   // bit clear reaches the indexed bit.
   a_bit_clr_any: assert property (
      CE && BIT_CLR_INS && !BIT_SET_INS && !wr_lo && !wr_hi
      |=> !RX_ENABLE_MASK[$past(BIT_INDEX)])
      else $error("bit clear instruction missed its bit");

   a_bit13_set: assert property (
      CE && BIT13_SET_STROBE && !RADIO_OFF_STROBE && !bus_sel[13]
      && !(MASK_AND_INSTRUCTION && !AND_OPERAND[13])
      |=> RX_ENABLE_MASK[13])
      else $error("bit 13 set strobe had no effect");

   a_bit13_clear: assert property (
      CE && BIT13_CLEAR_STROBE && !BIT13_SET_STROBE && !bus_sel[13]
      && !(MASK_OR_INSTRUCTION && OR_OPERAND[13])
      |=> !RX_ENABLE_MASK[13])
      else $error("bit 13 clear strobe had no effect");

   // high byte written at the upper address.
   a_high_write: assert property (
      CE && wr_hi |=> RX_ENABLE_MASK[15:8] == $past(WDATA))
      else $error("high mask byte write lost");

   // a low byte write and the receive strobe both apply.
   a_both_apply: assert property (
      CE && wr_lo && !BIT_SET_INS && !BIT_CLR_INS && RECEIVE_ON_STROBE
      && !RADIO_OFF_STROBE |=> RX_ENABLE_MASK[15])
      else $error("non-conflicting updates not both applied");

   // transmit strobe beats a clearing AND on bit 14.
   a_tx_beats_and: assert property (
      CE && TRANSMIT_ON_STROBE && r.ctrl[0] && MASK_AND_INSTRUCTION
      && !AND_OPERAND[14] && !RADIO_OFF_STROBE && !bus_sel[14]
      |=> RX_ENABLE_MASK[14])
      else $error("strobe priority broken on bit 14");

   // plain events always set their flags.
   a_flag_set: assert property (
      CE && EXC_EVENT[2:0] != 3'h0
      |=> (EXCEPTION_PENDING[2:0] & $past(EXC_EVENT[2:0]))
          == $past(EXC_EVENT[2:0]))
      else $error("exception event did not set its flag");

   // a write with no event only keeps flags under its ones.
   a_flag_write_zero: assert property (
      CE && wr_exc && exc_ev == 8'h00
      |=> EXCEPTION_PENDING == ($past(r.exc) & $past(WDATA)))
      else $error("flag write did more than clear");

   // overrun event lands in bit 6.
   a_flag_bit6: assert property (
      CE && EXC_EVENT[6] |=> EXCEPTION_PENDING[6])
      else $error("receive overrun flag not in bit 6");

   // an ignored underrun leaves its flag alone.
   a_ignore_flag: assert property (
      CE && r.ctrl[1] && !wr_exc
      |=> EXCEPTION_PENDING[3] == $past(r.exc[3]))
      else $error("ignored underrun changed its flag");

   // interrupt level tracks enabled status bits.
   a_irq_level: assert property (
      IRQ == |(r.irq_stat & r.irq_mask))
      else $error("interrupt level disagrees with status");

   // read data stand for one cycle only.
   a_rdata_idle: assert property (
      CE && !RD |=> RDATA == 8'h00)
      else $error("read data not zero outside a read");

   // only the three low control bits are kept.
   a_ctrl_write: assert property (
      CE && wr_ctrl |=> r.ctrl == $past(WDATA[2:0]))
      else $error("control write not kept");

   c_radio_off: cover property (CE && RADIO_OFF_STROBE && r.mask != 0);
   c_conflict: cover property (CE && wr_hi && RECEIVE_ON_STROBE);
   c_mask_zero: cover property (CE && exc_ev[7]);
   c_irq_rise: cover property (!IRQ ##1 IRQ);
   c_and_or: cover property (CE && MASK_AND_INSTRUCTION && MASK_OR_INSTRUCTION);

endmodule

// [rtl/rxem_map.svh]
// Constants of the receive-enable mask and exception flag register bank.
// Assumes a byte-wide register port with twelve address bits.
`ifndef RXEM_MAP_SVH
`define RXEM_MAP_SVH

// Register offsets.
`define RXEM_OFF_CTRL      12'h00D
`define RXEM_OFF_MASK_LO   12'h00E
`define RXEM_OFF_MASK_HI   12'h00F
`define RXEM_OFF_EXC_LO    12'h010
`define RXEM_OFF_IRQ_STAT  12'h020
`define RXEM_OFF_IRQ_MASK  12'h021

// Reset values.
`define RXEM_CTRL_RESET    3'h1
`define RXEM_MASK_RESET    16'h0000
`define RXEM_BYTE_RESET    8'h00

// Control field positions.
`define RXEM_CTRL_TXSET    0
`define RXEM_CTRL_UNDIGN   1
`define RXEM_CTRL_ACKFRC   2

// Mask bits touched by dedicated strobes.
`define RXEM_BIT_TXON      14
`define RXEM_BIT_RXON      15
`define RXEM_BIT_STB13     13

// Exception bit positions.
`define RXEM_EXC_UNDERRUN  3
`define RXEM_EXC_MASKZERO  7

`endif

// [rtl/rxem_pkg.sv]
// Types of the receive-enable mask and exception flag register bank.
// Assumes the constants header is compiled alongside.
package rxem_pkg;

   typedef logic [11:0] rxem_addr_type;
   typedef logic [7:0]  rxem_byte_type;
   typedef logic [15:0] rxem_mask_type;

   // Whole state of the bank, registered in one process.
   typedef struct packed {
      logic [2:0]    ctrl;
      rxem_mask_type mask;
      rxem_byte_type exc;
      rxem_byte_type irq_stat;
      rxem_byte_type irq_mask;
      rxem_byte_type rdata;
      logic          ack_pend;
      logic          tx_abort;
      logic          rx_auto;
      logic          irq;
   } rxem_state_type;

endpackage

// [sim/rxem_host.sv]
// Host model: strobes, instructions, events and register port requests.
// Assumes one caller at a time and a free-running clock.
`timescale 1ns/100ps

module rxem_host
(
   input  wire logic        clk,
   output      logic [17:0] ctl,
   output      logic [15:0] or_op,
   output      logic [15:0] and_op,
   output      logic [3:0]  idx,
   output      logic [11:0] addr,
   output      logic [7:0]  wdata
);
   // Idle values, so nothing is unknown at time zero.
   initial
   begin
      ctl = 18'h00000;
      or_op = 16'h0000;
      and_op = 16'hFFFF;
      idx = 4'h0;
      addr = 12'h000;
      wdata = 8'h00;
   end

   // One request per call: set after an edge, held through the taking edge,
   // released after it. Read and write never share a call.
   task automatic drive(input logic [17:0] c, input logic [15:0] o, n,
                        input logic [3:0] x, input logic [11:0] a,
                        input logic [7:0] d);
      @(posedge clk);
      ctl <= c;
      or_op <= o;
      and_op <= n;
      idx <= x;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      ctl <= 18'h00000;
   endtask
endmodule

// [sim/rxem_regs_tb.sv]
// Self-checking bench of the mask and exception register bank.
// Assumes the host model in its own file; clock enable is high except for one low stretch near the end.
`timescale 1ns/100ps

module rxem_regs_tb
   import rxem_pkg::*;
;
   logic          CLOCK = 1'b0;
   logic          SRST = 1'b1;
   logic          ack_in = 1'b0;
   logic          und_in = 1'b0;
   logic          ce = 1'b1;
   logic [17:0]   ctl;
   logic [15:0]   or_op;
   logic [15:0]   and_op;
   logic [3:0]    idx;
   logic [11:0]   addr;
   logic [7:0]    wdata;
   rxem_byte_type rdata;
   rxem_byte_type exc_out;
   rxem_mask_type mask_out;
   logic          auto_en;
   logic          ack_out;
   logic          tx_abort;
   logic          irq;
   int            errors = 0;
   int            total_checks = 0;
   logic [7:0]    q[$];
   logic          rd_q = 1'b0;
   logic [15:0]   r = 16'hCC5E;
   logic [15:0]   m = 16'h0000;
   logic [15:0]   nm;
   logic [15:0]   o;
   logic [15:0]   n;
   logic [7:0]    exc = 8'h00;
   logic [10:0]   c;
   logic [6:0]    ev;
   logic [11:0]   a;

   always #4 CLOCK = ~CLOCK;

   rxem_host i_host (.clk(CLOCK), .ctl(ctl), .or_op(or_op), .and_op(and_op),
      .idx(idx), .addr(addr), .wdata(wdata));

   rxem_regs i_dut (.CLOCK(CLOCK), .SRST(SRST), .CE(ce), .ADDR(addr),
      .WDATA(wdata), .WR(ctl[10]), .RD(ctl[9]), .RDATA(rdata),
      .BIT_SET_INS(ctl[8]), .BIT_CLR_INS(ctl[7]), .BIT_INDEX(idx),
      .TRANSMIT_ON_STROBE(ctl[6]), .RECEIVE_ON_STROBE(ctl[5]),
      .RADIO_OFF_STROBE(ctl[4]), .MASK_OR_INSTRUCTION(ctl[3]),
      .OR_OPERAND(or_op), .MASK_AND_INSTRUCTION(ctl[2]),
      .AND_OPERAND(and_op), .BIT13_SET_STROBE(ctl[1]),
      .BIT13_CLEAR_STROBE(ctl[0]), .EXC_EVENT(ctl[17:11]),
      .ACK_PENDING_IN(ack_in), .TX_UNDERRUN_IN(und_in),
      .RX_ENABLE_MASK(mask_out), .RX_AUTO_ENABLE(auto_en),
      .ACK_PENDING_OUT(ack_out), .TX_ABORT(tx_abort),
      .EXCEPTION_PENDING(exc_out), .IRQ(irq));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic rd(input logic [11:0] ra, input logic [7:0] e);
      q.push_back(e);
      i_host.drive(18'h00200, 16'h0000, 16'hFFFF, 4'h0, ra, 8'h00);
   endtask

   task automatic wr(input logic [11:0] wa, input logic [7:0] d);
      i_host.drive(18'h00400, 16'h0000, 16'hFFFF, 4'h0, wa, d);
   endtask

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   task automatic nxt();
      repeat (5) r = lfsr(r);
   endtask

   // Strobes apply lowest priority first so higher ones overwrite; the
   // data bus goes last because it beats them all.
   function automatic logic [15:0] upd(input logic [15:0] v);
      if (c[0]) v[13] = 1'b0;
      if (c[1]) v[13] = 1'b1;
      if (c[2]) v = v & n;
      if (c[3]) v = v | o;
      if (c[5]) v[15] = 1'b1;
      if (c[6]) v[14] = 1'b1;
      if (c[4]) v = 16'h0000;
      if (c[7]) v[o[3:0]] = 1'b0;
      if (c[8]) v[o[3:0]] = 1'b1;
      if (c[10] && a == 12'h00E) v[7:0] = n[7:0];
      if (c[10] && a == 12'h00F) v[15:8] = n[7:0];
      return v;
   endfunction

   // Read data are judged in the cycle after the read strobe only.
   always @(posedge CLOCK) rd_q <= ctl[9];
   always @(negedge CLOCK) if (rd_q) check(rdata, q.pop_front());

   initial
   begin
      repeat (20000) @(posedge CLOCK);
      errors++;
      stop_test();
   end

   initial
   begin
      repeat (4) @(posedge CLOCK);
      SRST <= 1'b0;
      und_in <= 1'b1;
      rd(12'h00D, 8'h01);
      rd(12'h00E, 8'h00);
      rd(12'h010, 8'h00);
      rd(12'h0FF, 8'h00);
      wr(12'h00D, 8'hFF);
      rd(12'h00D, 8'h07);
      check(ack_out, 1'b1);
      check(tx_abort, 1'b0);
      wr(12'h00D, 8'h00);
      @(negedge CLOCK);
      @(negedge CLOCK);
      check(ack_out, 1'b0);
      check(tx_abort, 1'b1);
      i_host.drive(18'h00040, 16'h0000, 16'hFFFF, 4'h0, 12'h000, 8'h00);
      rd(12'h00F, 8'h00);
      wr(12'h00D, 8'h01);
      i_host.drive(18'h00040, 16'h0000, 16'hFFFF, 4'h0, 12'h000, 8'h00);
      rd(12'h00F, 8'h40);
      m = 16'h4000;
      // Interrupt raised, read clears status, flags clear by zeros only.
      wr(12'h021, 8'h02);
      i_host.drive(18'h01000, 16'h0000, 16'hFFFF, 4'h0, 12'h000, 8'h00);
      @(negedge CLOCK);
      check(irq, 1'b1);
      rd(12'h020, 8'h02);
      @(negedge CLOCK);
      check(irq, 1'b0);
      wr(12'h010, 8'hFF);
      rd(12'h010, 8'h02);
      wr(12'h010, 8'hFD);
      rd(12'h010, 8'h00);
      // Random mixes of strobes, instructions, bus updates and events.
      repeat (150)
      begin
         nxt();
         c = {r[15:14] != 2'h3, 1'b0, r[8:0] & r[15:7]};
         a = 12'h00E + {10'h000, r[15:14]};
         nxt();
         ev = r[6:0] & r[13:7];
         nxt();
         o = r;
         nxt();
         n = r;
         nm = upd(m);
         if (c[10] && a == 12'h010) exc = exc & n[7:0];
         exc = exc | {m != 16'h0000 && nm == 16'h0000, ev};
         m = nm;
         i_host.drive({ev, c}, o, n, o[3:0], a, n[7:0]);
         @(negedge CLOCK);
         check(auto_en, m != 16'h0000);
         check(mask_out, m);
         check(exc_out, exc);
         rd(12'h00E, m[7:0]);
         rd(12'h00F, m[15:8]);
         rd(12'h010, exc);
      end
      // Clock enable low: a radio-off strobe must leave the mask.
      @(posedge CLOCK) ce <= 1'b0;
      i_host.drive(18'h00010, 16'h0000, 16'hFFFF, 4'h0, 12'h000, 8'h00);
      @(negedge CLOCK);
      check(mask_out, m);
      @(posedge CLOCK) ce <= 1'b1;
      // Underrun event ignored while the ignore bit is set, then taken.
      wr(12'h00D, 8'h03);
      i_host.drive(18'h04000, 16'h0000, 16'hFFFF, 4'h0, 12'h000, 8'h00);
      rd(12'h010, exc);
      wr(12'h00D, 8'h01);
      i_host.drive(18'h04000, 16'h0000, 16'hFFFF, 4'h0, 12'h000, 8'h00);
      exc = exc | 8'h08;
      rd(12'h010, exc);
      repeat (2) @(negedge CLOCK);
      stop_test();
   end
endmodule
